// *** shared/mfab_pkg.sv ***
// Package: register map, field layout and types for the flow action decoder
package mfab_pkg;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 4;
	localparam int ENTRIES = 16;
	localparam logic [7:0] OFF_EGR_BASE = 8'h00;
	localparam logic [7:0] OFF_IGR_BASE = 8'h40;
	localparam logic [7:0] OFF_NM_NCP = 8'h80;
	localparam logic [7:0] OFF_NM_CP = 8'h84;
	localparam logic [7:0] OFF_HDR_CFG = 8'h88;
	localparam logic [7:0] OFF_CP_ETYPE = 8'h8C;
	localparam logic [7:0] OFF_STATUS = 8'h90;
	localparam logic [7:0] REGION_MASK = 8'hC0;
	localparam logic [7:0] REGION_EGR = 8'h00;
	localparam logic [7:0] REGION_IGR = 8'h40;
	localparam int WORD_LSB = 2;
	localparam logic [7:0] OFF_MASK_LO = 8'h94;
	localparam logic [7:0] OFF_MASK_HI = 8'h98;
	// Writable bits of each action word; the rest store and read as zero
	localparam logic [31:0] EGR_RW_MASK = 32'h001F_FFFF;
	localparam logic [31:0] IGR_RW_MASK = 32'h0003_FFFF;
	// Flow type codes
	localparam logic [1:0] FT_BYPASS = 2'h0;
	localparam logic [1:0] FT_DROP = 2'h1;
	localparam logic [1:0] FT_MACSEC = 2'h2;
	localparam logic [1:0] PORT_RESERVED = 2'h1;
	localparam logic [1:0] VAL_STRICT = 2'h2;
	localparam logic [2:0] HDR_SIZE_MAX = 3'h7;
	localparam logic [15:0] CP_ETYPE_RST = 16'h0000;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [7:0] HDR_UNIT = 8'h02;
	localparam logic [1:0] TAGS_MAX = 2'h2;

	typedef enum logic [1:0] {MFAB_UNTAGGED, MFAB_TAGGED, MFAB_BADTAG, MFAB_KAY} mfab_tagcls_e;

	// Egress flow action word, bits 31..21 read as zero
	typedef struct packed {
		logic [10:0] rsvd;
		logic conf_protect;
		logic [6:0] conf_offset;
		logic [1:0] tag_bypass;
		logic sci_bit_on;
		logic end_station_bit_on;
		logic include_sci;
		logic association_active;
		logic protect_frame;
		logic [1:0] drop_method;
		logic [1:0] dest_port;
		logic [1:0] flow_type;
	} mfab_egr_s;

	typedef struct packed {
		logic [13:0] rsvd;
		logic [6:0] conf_offset;
		logic [1:0] validate_level;
		logic association_active;
		logic replay_protect;
		logic drop_nonreserved;
		logic [1:0] drop_method;
		logic [1:0] dest_port;
		logic [1:0] flow_type;
	} mfab_igr_s;

	// One nibble-aligned byte per tag class: {drop_method, dest_port, flow_type(bypass/drop)}
	typedef struct packed {
		logic [1:0] rsvd;
		logic [1:0] drop_method;
		logic [1:0] dest_port;
		logic [1:0] flow_type;
	} mfab_nm_s;

	// Lookup result presented with the packet
	typedef struct packed {
		logic egress;
		logic sa_hit;
		logic [3:0] sa_index;
		logic control_pkt;
		mfab_tagcls_e tag_class;
		logic [1:0] source_port;
		logic [1:0] parsed_tags;
	} mfab_req_s;

	// Decoded action handed to the transform stage
	typedef struct packed {
		logic do_bypass;
		logic do_drop;
		logic do_macsec;
		logic [1:0] dest_port;
		logic [1:0] drop_method;
		logic protect_frame;
		logic association_active;
		logic include_sci;
		logic end_station_bit_on;
		logic sci_bit_on;
		logic [1:0] tags_bypassed;
		logic [6:0] conf_offset;
		logic conf_protect;
		logic replay_protect;
		logic [1:0] validate_level;
		logic kay_bypass;
	} mfab_act_s;
endpackage

// *** hw/mfab_table.sv ***
// Flow action memory with registered read port
`timescale 1ns/1ns
`default_nettype none
module mfab_table (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Write port
	input wire logic wr_en,
	input wire logic [mfab_pkg::IDX_W-1:0] wr_idx,
	input wire logic [31:0] wr_data,
	// Read port, data one cycle after index
	input wire logic [mfab_pkg::IDX_W-1:0] rd_idx,
	output logic [31:0] rd_data
);
	logic [31:0] mem [mfab_pkg::ENTRIES];

	// Cleared at reset so an untouched entry decodes as bypass to the common port
	genvar gi;
	generate
		for (gi = 0; gi < mfab_pkg::ENTRIES; gi++) begin : g_ent
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n)
					mem[gi] <= mfab_pkg::ZERO32;
				else if (wr_en && wr_idx == gi[mfab_pkg::IDX_W-1:0])
					mem[gi] <= wr_data;
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			rd_data <= mfab_pkg::ZERO32;
		else
			rd_data <= mem[rd_idx];
	end
endmodule
`default_nettype wire

// *** hw/mfab_decoder.sv ***
// Per-flow action decoder with no-match defaults and bypass formats
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module mfab_decoder (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Register port
	input wire logic [mfab_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Lookup result in
	input wire logic req_valid,
	input wire mfab_pkg::mfab_req_s req,
	input wire logic [15:0] inner_ethertype,
	input wire logic secure_format,
	// Decoded action out, one cycle after the table read
	output logic act_valid,
	output mfab_pkg::mfab_act_s act,
	// Header bypass parse controls
	output logic hdr_bypass_on,
	output logic [7:0] sectag_offset,
	output logic use_outer_addr,
	output logic [15:0] ctrl_ethertype_sel,
	output logic [63:0] field_match_mask
);
	logic [1:0] unused_tags;
	logic [31:0] egr_rd;
	logic [31:0] igr_rd;
	logic [31:0] nm_ncp;
	logic [31:0] nm_cp;
	logic [2:0] hdr_size;
	logic [15:0] cp_etype;
	logic [63:0] field_mask;
	logic [31:0] mask_lo;
	logic [31:0] mask_hi;
	logic [31:0] rd_mux;
	logic rd_from_tab;
	logic rd_tab_igr;
	logic rd_pend;
	logic [7:0] rd_addr_q;
	logic stg_valid;
	mfab_pkg::mfab_req_s stg;
	logic stg_secfmt;
	logic [15:0] stg_etype;
	logic [7:0] refused_cnt;
	logic egr_wr;
	logic igr_wr;
	logic [mfab_pkg::IDX_W-1:0] tab_idx;
	logic [mfab_pkg::IDX_W-1:0] reg_idx;
	logic [7:0] addr8;
	mfab_pkg::mfab_act_s next_act;

	assign unused_tags = 2'h0;
	assign addr8 = reg_addr;
	assign reg_idx = addr8[mfab_pkg::WORD_LSB +: mfab_pkg::IDX_W];
	assign egr_wr = reg_wr && (addr8 & mfab_pkg::REGION_MASK) == mfab_pkg::REGION_EGR;
	assign igr_wr = reg_wr && (addr8 & mfab_pkg::REGION_MASK) == mfab_pkg::REGION_IGR;
	// Packet lookups own the read port; a software read of the table in the same cycle returns the entry at the lookup's index
	assign tab_idx = req_valid ? req.sa_index : reg_idx;

	mfab_table u_egr (
		.mclk(mclk),
		.arst_n(arst_n),
		.wr_en(egr_wr),
		.wr_idx(reg_idx),
		.wr_data(reg_wdata & mfab_pkg::EGR_RW_MASK),
		.rd_idx(tab_idx),
		.rd_data(egr_rd)
	);

	mfab_table u_igr (
		.mclk(mclk),
		.arst_n(arst_n),
		.wr_en(igr_wr),
		.wr_idx(reg_idx),
		.wr_data(reg_wdata & mfab_pkg::IGR_RW_MASK),
		.rd_idx(tab_idx),
		.rd_data(igr_rd)
	);

	// Static configuration registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			nm_ncp <= mfab_pkg::ZERO32;
			nm_cp <= mfab_pkg::ZERO32;
			hdr_size <= 3'h0;
			cp_etype <= mfab_pkg::CP_ETYPE_RST;
		end else if (reg_wr) begin
			case (addr8)
				mfab_pkg::OFF_NM_NCP: nm_ncp <= reg_wdata;
				mfab_pkg::OFF_NM_CP: nm_cp <= reg_wdata;
				mfab_pkg::OFF_HDR_CFG: hdr_size <= reg_wdata[2:0];
				mfab_pkg::OFF_CP_ETYPE: cp_etype <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// Per-bit masks for the first 64 bits of the variable field
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mask_lo <= mfab_pkg::ZERO32;
			mask_hi <= mfab_pkg::ZERO32;
		end else if (reg_wr && addr8 == mfab_pkg::OFF_MASK_LO) begin
			mask_lo <= reg_wdata;
		end else if (reg_wr && addr8 == mfab_pkg::OFF_MASK_HI) begin
			mask_hi <= reg_wdata;
		end
	end
	assign field_mask = {mask_hi, mask_lo};

	// Header bypass setup: size code n gives 2*(n+1) bytes only when nonzero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hdr_bypass_on <= 1'b0;
			sectag_offset <= 8'h00;
			field_match_mask <= 64'h0;
		end else begin
			hdr_bypass_on <= hdr_size != 3'h0;
			sectag_offset <= (hdr_size != 3'h0) ? 8'({hdr_size, 1'b0}) + mfab_pkg::HDR_UNIT : 8'h00;
			field_match_mask <= field_mask;
		end
	end

	// Read path: data one cycle after the strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_pend <= 1'b0;
			rd_addr_q <= 8'h00;
		end else begin
			rd_pend <= reg_rd;
			rd_addr_q <= addr8;
		end
	end
	assign rd_from_tab = (rd_addr_q & mfab_pkg::REGION_MASK) == mfab_pkg::REGION_EGR ||
		(rd_addr_q & mfab_pkg::REGION_MASK) == mfab_pkg::REGION_IGR;
	assign rd_tab_igr = (rd_addr_q & mfab_pkg::REGION_MASK) == mfab_pkg::REGION_IGR;

	always_comb begin
		rd_mux = mfab_pkg::ZERO32;
		if (rd_from_tab)
			rd_mux = rd_tab_igr ? igr_rd : egr_rd;
		else begin
			case (rd_addr_q)
				mfab_pkg::OFF_NM_NCP: rd_mux = nm_ncp;
				mfab_pkg::OFF_NM_CP: rd_mux = nm_cp;
				mfab_pkg::OFF_HDR_CFG: rd_mux = {29'h0, hdr_size};
				mfab_pkg::OFF_CP_ETYPE: rd_mux = {16'h0, cp_etype};
				mfab_pkg::OFF_STATUS: rd_mux = {23'h0, hdr_bypass_on, refused_cnt};
				default: rd_mux = mfab_pkg::ZERO32;
			endcase
		end
	end
	assign reg_rdata = rd_pend ? rd_mux : mfab_pkg::ZERO32;

	// Stage the request beside the table read
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stg_valid <= 1'b0;
			stg <= '0;
			stg_secfmt <= 1'b0;
			stg_etype <= 16'h0000;
		end else begin
			stg_valid <= req_valid;
			stg <= req;
			stg_secfmt <= secure_format;
			stg_etype <= inner_ethertype;
		end
	end

	// Control packet address selection in header bypass mode
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			use_outer_addr <= 1'b0;
			ctrl_ethertype_sel <= 16'h0000;
		end else if (stg_valid) begin
			use_outer_addr <= hdr_bypass_on && stg_etype == cp_etype;
			ctrl_ethertype_sel <= (hdr_bypass_on && stg_etype != cp_etype) ? stg_etype : 16'h0000;
		end
	end

	always_comb begin
		mfab_pkg::mfab_egr_s e;
		mfab_pkg::mfab_igr_s i;
		mfab_pkg::mfab_nm_s nm;
		logic [31:0] nmw;
		logic [1:0] ft;
		e = egr_rd;
		i = igr_rd;
		nmw = stg.control_pkt ? nm_cp : nm_ncp;
		nm = nmw[8*stg.tag_class +: 8];
		ft = mfab_pkg::FT_BYPASS;
		next_act = '0;
		if (stg.sa_hit && stg.egress) begin
			ft = e.flow_type;
			next_act.dest_port = e.dest_port;
			next_act.drop_method = e.drop_method;
			next_act.protect_frame = e.protect_frame;
			next_act.association_active = e.association_active;
			next_act.include_sci = e.include_sci;
			next_act.end_station_bit_on = e.end_station_bit_on;
			next_act.sci_bit_on = e.sci_bit_on;
			next_act.tags_bypassed = (e.tag_bypass > mfab_pkg::TAGS_MAX) ?
				mfab_pkg::TAGS_MAX : e.tag_bypass;
			next_act.conf_offset = e.conf_offset;
			next_act.conf_protect = e.conf_protect;
		end else if (stg.sa_hit) begin
			ft = i.flow_type;
			next_act.dest_port = i.dest_port;
			next_act.drop_method = i.drop_method;
			next_act.association_active = i.association_active;
			next_act.replay_protect = i.replay_protect;
			next_act.validate_level = i.validate_level;
			next_act.conf_offset = i.conf_offset;
			next_act.tags_bypassed = stg.parsed_tags;
			if (i.drop_nonreserved && stg.source_port != mfab_pkg::PORT_RESERVED)
				ft = mfab_pkg::FT_DROP;
		end else begin
			// Defaults only pass or drop; a MACsec code is refused as drop
			ft = (nm.flow_type == mfab_pkg::FT_BYPASS) ? mfab_pkg::FT_BYPASS : mfab_pkg::FT_DROP;
			next_act.dest_port = nm.dest_port;
			next_act.drop_method = nm.drop_method;
			next_act.tags_bypassed = stg.egress ? unused_tags : stg.parsed_tags;
		end
		// KaY frames pass untouched unless their action is drop or the reserved code, and are flagged with kay_bypass
		if (stg.tag_class == mfab_pkg::MFAB_KAY && ft != mfab_pkg::FT_DROP && ft != 2'h3) begin
			ft = mfab_pkg::FT_BYPASS;
			next_act.kay_bypass = 1'b1;
		end
		if (hdr_bypass_on && stg_secfmt && ft == mfab_pkg::FT_MACSEC && stg.parsed_tags != 2'h0)
			ft = mfab_pkg::FT_DROP;
		case (ft)
			mfab_pkg::FT_BYPASS: next_act.do_bypass = 1'b1;
			mfab_pkg::FT_DROP: next_act.do_drop = 1'b1;
			mfab_pkg::FT_MACSEC: next_act.do_macsec = 1'b1;
			default: next_act.do_drop = 1'b1;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			act_valid <= 1'b0;
			act <= '0;
		end else begin
			act_valid <= stg_valid;
			if (stg_valid)
				act <= next_act;
		end
	end

	// Saturating count of tagged secure-format frames seen under header bypass, whatever their action
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			refused_cnt <= 8'h00;
		else if (stg_valid && hdr_bypass_on && stg_secfmt && stg.parsed_tags != 2'h0 &&
			refused_cnt != 8'hFF)
			refused_cnt <= refused_cnt + 8'h01;
	end
endmodule
`default_nettype wire

// *** sim/mfab_decoder_properties.sv ***
// Checker: timing and decode relations at the decoder ports
`timescale 1ns/1ns
`default_nettype none
module mfab_decoder_properties (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Lookup and action
	input wire logic req_valid,
	input wire mfab_pkg::mfab_req_s req,
	input wire logic act_valid,
	input wire mfab_pkg::mfab_act_s act,
	// Header bypass
	input wire logic hdr_bypass_on,
	input wire logic [7:0] sectag_offset
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	act_latency_a: assert property (req_valid |-> ##2 act_valid)
		else $error("action missing two cycles after request");
	act_cause_a: assert property (act_valid |-> $past(req_valid, 2))
		else $error("action without a request");
	act_hold_a: assert property (!act_valid |-> $stable(act))
		else $error("action changed without valid");
	one_kind_a: assert property (act_valid |->
		$onehot({act.do_bypass, act.do_drop, act.do_macsec}))
		else $error("action kind not one-hot");
	nomatch_kind_a: assert property (act_valid && !$past(req.sa_hit, 2) |->
		!act.do_macsec)
		else $error("unmatched packet sent to processing");
	kay_bypass_a: assert property (act_valid && !$past(req.sa_hit, 2) &&
		$past(req.tag_class, 2) == mfab_pkg::MFAB_KAY |-> act.do_drop || act.kay_bypass)
		else $error("key agreement packet not bypassed");
	tag_clamp_a: assert property (act_valid |-> act.tags_bypassed <= mfab_pkg::TAGS_MAX)
		else $error("bypassed tag count above two");
	ingress_tags_a: assert property (act_valid && act.do_macsec && !$past(req.egress, 2) |->
		act.tags_bypassed == $past(req.parsed_tags, 2))
		else $error("ingress tag count not from parser");
	hdr_off_a: assert property (!hdr_bypass_on |-> sectag_offset == 8'h00)
		else $error("offset nonzero with header bypass off");
	hdr_size_a: assert property (hdr_bypass_on |->
		sectag_offset inside {[8'h04:8'h10]} && !sectag_offset[0])
		else $error("header field size out of range");

	cover property (act_valid && act.do_macsec);
	cover property (act_valid && act.kay_bypass);
	cover property (hdr_bypass_on);
endmodule
bind mfab_decoder mfab_decoder_properties i_props (.mclk(mclk), .arst_n(arst_n),
	.req_valid(req_valid), .req(req), .act_valid(act_valid), .act(act),
	.hdr_bypass_on(hdr_bypass_on), .sectag_offset(sectag_offset));
`default_nettype wire

// *** sim/mfab_pipe_model.sv ***
// Packet pipeline model presenting one lookup result per request
`timescale 1ns/1ns
`default_nettype none
module mfab_pipe_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Bench control
	input wire logic go,
	input wire mfab_pkg::mfab_req_s lreq,
	// Lookup result
	output logic req_valid,
	output mfab_pkg::mfab_req_s req
);
	// Outside a pulse the result lines toggle, so late sampling shows up
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			req_valid <= 1'b0;
			req <= '0;
		end else if (go) begin
			req_valid <= 1'b1;
			req <= lreq;
		end else begin
			req_valid <= 1'b0;
			req <= ~req;
		end
	end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Testbench: register access, matched and unmatched decode, header bypass
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic mclk, arst_n, reg_wr, reg_rd, go, req_valid, act_valid, secure_format;
	logic hdr_bypass_on, use_outer_addr;
	logic [7:0] reg_addr, sectag_offset;
	logic [31:0] reg_wdata, reg_rdata, w, rnd;
	logic [15:0] inner_ethertype, ctrl_ethertype_sel;
	logic [63:0] field_match_mask;
	logic [1:0] sp;
	mfab_pkg::mfab_req_s lreq, req;
	mfab_pkg::mfab_act_s act;
	int err_total, checks_done;

	mfab_decoder i_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req(req), .inner_ethertype(inner_ethertype),
		.secure_format(secure_format), .act_valid(act_valid), .act(act),
		.hdr_bypass_on(hdr_bypass_on), .sectag_offset(sectag_offset),
		.use_outer_addr(use_outer_addr), .ctrl_ethertype_sel(ctrl_ethertype_sel),
		.field_match_mask(field_match_mask));
	mfab_pipe_model i_pipe (.mclk(mclk), .arst_n(arst_n), .go(go), .lreq(lreq),
		.req_valid(req_valid), .req(req));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected {macsec, drop, bypass}; reserved code acts as drop
	function automatic logic [2:0] kind(logic [1:0] f);
		return (f == mfab_pkg::FT_BYPASS) ? 3'h1 : (f == mfab_pkg::FT_MACSEC) ? 3'h4 : 3'h2;
	endfunction
	task automatic check(logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask
	task automatic look(mfab_pkg::mfab_req_s r);
		int n;
		@(posedge mclk);
		lreq <= r;
		go <= 1'b1;
		inner_ethertype <= rnd[15:0];
		secure_format <= rnd[16];
		@(posedge mclk);
		go <= 1'b0;
		n = 0;
		while (act_valid !== 1'b1 && n < 8) begin
			@(posedge mclk);
			#1 n++;
		end
		if (n == 8) begin
			err_total++;
			$display("ERROR at %0t: no action", $time);
			give_verdict();
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		arst_n = 1'b0;
		{reg_wr, reg_rd, go, secure_format} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		inner_ethertype = 16'h0000;
		lreq = '0;
		rnd = 32'h6559;
		err_total = 0;
		checks_done = 0;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		rd(8'hA0, 32'h0000_0000);
		rd(mfab_pkg::OFF_NM_CP, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			w = {rnd[31:2], i[1:0]};
			wr(mfab_pkg::OFF_EGR_BASE + 8'(4 * i), w);
			rd(mfab_pkg::OFF_EGR_BASE + 8'(4 * i), w & 32'h001F_FFFF);
			look({1'b1, 1'b1, i[3:0], rnd[22], mfab_pkg::MFAB_TAGGED, rnd[24:23], 2'h0});
			check({act.do_macsec, act.do_drop, act.do_bypass, act.dest_port, act.drop_method,
				act.sci_bit_on, act.end_station_bit_on, act.include_sci, act.association_active,
				act.protect_frame, act.conf_offset, act.conf_protect},
				{kind(w[1:0]), w[3:2], w[5:4], w[10:6], w[19:13], w[20]});
			check(act.tags_bypassed, (w[12:11] == 2'h3) ? 2'h2 : w[12:11]);
		end
		$display("egress test done");
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			w = {rnd[31:2], i[1:0]};
			sp = rnd[25:24];
			wr(mfab_pkg::OFF_IGR_BASE + 8'(4 * i), w);
			rd(mfab_pkg::OFF_IGR_BASE + 8'(4 * i), w & 32'h0003_FFFF);
			look({1'b0, 1'b1, i[3:0], 1'b0, mfab_pkg::MFAB_TAGGED, sp, 2'(rnd[20:19] % 3)});
			check({act.do_macsec, act.do_drop, act.do_bypass, act.dest_port, act.drop_method,
				act.validate_level, act.association_active, act.replay_protect, act.conf_offset},
				{kind((w[6] && sp != mfab_pkg::PORT_RESERVED) ? mfab_pkg::FT_DROP : w[1:0]),
				w[3:2], w[5:4], w[10:7], w[17:11]});
		end
		$display("ingress test done");
		for (int c = 0; c < 2; c++) begin
			rnd = lfsr(rnd);
			w = rnd;
			for (int k = 0; k < 4; k++) w[8 * k +: 2] = 2'(k + c);
			wr(c ? mfab_pkg::OFF_NM_CP : mfab_pkg::OFF_NM_NCP, w);
			for (int k = 0; k < 4; k++) begin
				look({w[k], 1'b0, 4'h0, c[0], mfab_pkg::mfab_tagcls_e'(k), 2'h0, 2'h0});
				check({act.do_macsec, act.do_drop, act.do_bypass, act.drop_method, act.dest_port},
					{(w[8 * k +: 2] == 2'h0) ? 3'h1 : 3'h2, w[8 * k + 2 +: 4]});
			end
		end
		$display("no-match test done");
		for (int s = 0; s < 8; s++) begin
			wr(mfab_pkg::OFF_HDR_CFG, 32'(s));
			@(posedge mclk);
			#1 check({hdr_bypass_on, sectag_offset},
				{s != 0, (s != 0) ? 8'(2 * s + 2) : 8'h00});
		end
		wr(mfab_pkg::OFF_CP_ETYPE, 32'h0000_88E5);
		wr(mfab_pkg::OFF_MASK_LO, 32'hA5A5_0F0F);
		wr(mfab_pkg::OFF_MASK_HI, 32'h0000_00C3);
		wr(mfab_pkg::OFF_EGR_BASE, 32'h0000_0002);
		check(field_match_mask[31:0], 32'hA5A5_0F0F);
		check(field_match_mask[63:32], 32'h0000_00C3);
		rnd = 32'h0001_88E5;
		look({1'b1, 1'b1, 4'h0, 1'b0, mfab_pkg::MFAB_TAGGED, 2'h0, 2'h1});
		check({act.do_macsec, act.do_drop, act.do_bypass}, 3'h2);
		check({use_outer_addr, ctrl_ethertype_sel}, {1'b1, 16'h0000});
		rnd = 32'h0000_1234;
		look({1'b1, 1'b1, 4'h0, 1'b0, mfab_pkg::MFAB_TAGGED, 2'h0, 2'h1});
		check({act.do_macsec, act.do_drop, act.do_bypass}, 3'h4);
		check({use_outer_addr, ctrl_ethertype_sel}, {1'b0, 16'h1234});
		rd(mfab_pkg::OFF_STATUS, 32'h0000_0101);
		wr(mfab_pkg::OFF_HDR_CFG, 32'h0000_0000);
		$display("header bypass test done");
		give_verdict();
	end
endmodule
`default_nettype wire
